// ### meter_regs_defines.svh
// offsets, bit positions, limits and reset values of the meter register bank
// assumes inclusion by the package and the checker module
`ifndef METER_REGS_DEFINES_SVH
`define METER_REGS_DEFINES_SVH

// -------------------------------------------------
// function codes and exception codes
// -------------------------------------------------
`define FC_RD_DISC  8'h02
`define FC_RD_HOLD  8'h03
`define FC_RD_INP   8'h04
`define FC_WR_ONE   8'h06
`define FC_WR_MANY  8'h10
`define EXC_FUNC    8'h01
`define EXC_ADDR    8'h02
`define EXC_VALUE   8'h03

// -------------------------------------------------
// word offsets
// -------------------------------------------------
`define OFS_STATUS  16'h00CD
`define OFS_OUTWORD 16'h00CF
`define OFS_INWORD  16'h00D1
`define OFS_ACK     16'hEA67
`define OFS_NOMI    16'hC34F
`define OFS_WIRING  16'hC351
`define OFS_VTUSED  16'hC353
`define OFS_PRIV    16'hC355
`define OFS_SECV    16'hC357
`define OFS_PRII    16'hC35B
`define OFS_SECI    16'hC35D
`define OFS_DIR     16'hC363
`define OFS_ENERGY  16'hC369
`define OFS_ACTION  16'hC373
`define OFS_SOURCE  16'hC375
`define OFS_RATIO   16'hC377
`define OFS_LENGTH  16'hC379
`define OFS_TMO     16'hC37B
`define OFS_DIVIDER 16'hC37D

// -------------------------------------------------
// discrete bit addresses
// -------------------------------------------------
`define DSC_PARAM   16'h006C
`define DSC_PULSEL  16'h006E
`define DSC_REBOOT  16'h006F
`define DSC_COUNTER 16'h0070
`define DSC_PULSE   16'h0075
`define DSC_MENU    16'h007D
`define DSC_VOLT    16'h007E
`define DSC_CURR    16'h007F
`define DSC_INPUT   16'h00C8
`define DSC_OUTPUT  16'h012C

// -------------------------------------------------
// status word bit positions
// -------------------------------------------------
`define BIT_MENU    25
`define BIT_VOLT    26
`define BIT_CURR    27
`define BIT_PASSWD  31
`define BIT_PULSE   17
`define BIT_PARAM   8
`define BIT_PULSEL  10
`define BIT_REBOOT  11
`define BIT_COUNTER 12

// -------------------------------------------------
// setting slots, limits and reset values
// -------------------------------------------------
`define NSET        15
`define IDX_NONE    4'hF
`define MAX_NOMI    32'h0001869F
`define MAX_PRIV    32'h000F423F
`define MAX_SECV    32'h000001E0
`define SECI_ALT    32'h00000005
`define MAX_DIR     32'h00000007
`define MAX_MODE    16'h0002
`define MAX_ACTION  32'h00000002
`define MAX_SOURCE  32'h00000003
`define MAX_RATIO   32'h00000FA0
`define MIN_LENGTH  32'h0000001E
`define MAX_LENGTH  32'h000001F4
`define MAX_TMO     32'h00004650
`define MAX_DIVIDER 32'h00000003
`define RST_ONE     32'h00000001
`define RST_ZERO    32'h00000000
`define RST_LATCHED 4'h4

`endif

// ### meter_regs_pkg.sv
// types shared by the meter register bank
// assumes the defines header sits in the same folder
`include "meter_regs_defines.svh"

package meter_regs_pkg;

  typedef logic [31:0] word_t;

  // output behaviour of digital output zero
  typedef enum logic [1:0] {ACT_NONE, ACT_SWITCH, ACT_PULSE} out_action_e;

  // energy quantity counted by the pulse output
  typedef enum logic [1:0] {SRC_IMP_P, SRC_EXP_P, SRC_IMP_Q, SRC_EXP_Q} pulse_src_e;

  // whole state of the register bank
  typedef struct packed {
    logic [`NSET-1:0][31:0] setting;
    logic [3:0]             latched;
    logic [4:0]             live;
    logic [2:0]             diSync;
    logic                   diLevel;
    logic                   doLevel;
    logic [9:0]             unitKwh;
    logic                   rspValid;
    logic                   rspExc;
    logic [7:0]             rspExcCode;
    logic [31:0]            rspData;
  } regs_s;

endpackage

// ### meter_regs_props.sv
// checker of answers, status bits and settings of the meter register bank
// assumes a bind onto the bank top, one clock, asynchronous reset
`timescale 1ns/1ps
`include "meter_regs_defines.svh"

module meter_regs_checker
  import meter_regs_pkg::*;
(
  input logic        core_clk,
  input logic        arst_n,
  input logic        reqValid,
  input logic [7:0]  reqFunc,
  input logic [15:0] reqAddr,
  input logic [31:0] reqData,
  input logic        rspValid,
  input logic        rspExc,
  input logic [7:0]  rspExcCode,
  input logic [31:0] rspData,
  input logic        cfgMenuActive,
  input logic        busPasswordOn,
  input logic        pulseOverload,
  input out_action_e outputAction,
  input logic [1:0]  pulseDivider,
  input logic [9:0]  pulseUnitKwh
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ----------------
  // request shapes
  // ----------------
  sequence s_rd(a);
    reqValid && (reqFunc == `FC_RD_HOLD || reqFunc == `FC_RD_INP) && reqAddr == a;
  endsequence
  sequence s_wr(a);
    reqValid && reqFunc == `FC_WR_MANY && reqAddr == a;
  endsequence

  // ----------------
  // assertions
  // ----------------
  a_answer_next: assert property (
    reqValid |=> rspValid) else $error("no answer after request");
  a_status_live: assert property (
    s_rd(`OFS_STATUS) |=> !rspExc && rspData[`BIT_MENU] == $past(cfgMenuActive, 2)
      && rspData[`BIT_PASSWD] == $past(busPasswordOn, 2)) else $error("live bit wrong");
  a_pulse_live: assert property (
    s_rd(`OFS_STATUS) |=> rspData[`BIT_PULSE] == $past(pulseOverload, 2))
    else $error("pulse live bit wrong");
  a_disc_menu: assert property (
    reqValid && reqFunc == `FC_RD_DISC && reqAddr == `DSC_MENU
      |=> rspData[0] == $past(cfgMenuActive, 2)) else $error("menu bit wrong");
  a_pulse_latch: assert property (
    $rose(pulseOverload) ##1 !reqValid [*3] ##1 s_rd(`OFS_STATUS)
      |=> rspData[`BIT_PULSEL]) else $error("pulse event not latched");
  a_bad_length: assert property (
    s_wr(`OFS_LENGTH) ##0 (reqData < `MIN_LENGTH || reqData > `MAX_LENGTH)
      |=> rspExc && rspExcCode == `EXC_VALUE) else $error("range not refused");
  a_single_write: assert property (
    reqValid && reqFunc == `FC_WR_ONE && reqAddr == `OFS_LENGTH
      |=> rspExc && rspExcCode == `EXC_FUNC) else $error("single write taken");
  a_action_set: assert property (
    s_wr(`OFS_ACTION) ##0 (reqData <= `MAX_ACTION)
      |=> !rspExc && 2'(outputAction) == $past(reqData[1:0])) else $error("action wrong");
  a_unit_scale: assert property (
    $stable(pulseDivider) |-> pulseUnitKwh == (pulseDivider == 2'h0 ? 10'h1 :
      pulseDivider == 2'h1 ? 10'hA : pulseDivider == 2'h2 ? 10'h64 : 10'h3E8))
    else $error("energy unit wrong");
endmodule

bind meter_status_settings_regs meter_regs_checker u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reqValid(reqValid), .reqFunc(reqFunc),
  .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspExc(rspExc),
  .rspExcCode(rspExcCode), .rspData(rspData), .cfgMenuActive(cfgMenuActive),
  .busPasswordOn(busPasswordOn), .pulseOverload(pulseOverload),
  .outputAction(outputAction), .pulseDivider(pulseDivider), .pulseUnitKwh(pulseUnitKwh));

// ### meter_status_settings_regs.sv
// status, diagnostics and settings register bank reached by Modbus requests
// assumes a frame layer hands over one decoded request per cycle and takes
// the registered answer one cycle later; status levels come from core_clk logic
`timescale 1ns/1ps

// Contract
// - output zero state in read-only word
// - input zero state in read-only word
// - live status bits follow their conditions
// - live pulse overload in word and bit
// - latched events stay set until acknowledged
// - only latched bits need acknowledgement
// - status word readable by both read codes
// - discrete read answers listed bit addresses
// - settings read both codes, written multiple
// - direction field three phase invert bits
// - output action none, switching or pulse
// - pulse source index zero to three
// - pulse ratio and length range limits
// - remote timeout, zero disables
// - divider index scales energy unit
// - acknowledge command clears latched bits
module meter_status_settings_regs
  import meter_regs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        reqValid,
  input  wire logic [7:0]  reqFunc,
  input  wire logic [15:0] reqAddr,
  input  wire logic [31:0] reqData,
  output logic             rspValid,
  output logic             rspExc,
  output logic [7:0]       rspExcCode,
  output logic [31:0]      rspData,
  input  wire logic        digitalInputZero,
  input  wire logic        digitalOutputZero,
  input  wire logic        cfgMenuActive,
  input  wire logic        voltOverload,
  input  wire logic        currOverload,
  input  wire logic        busPasswordOn,
  input  wire logic        pulseOverload,
  input  wire logic        countersChangedEvt,
  output logic [31:0]      nominalRange,
  output logic             wiringType,
  output logic             vtUsed,
  output logic [31:0]      primaryVoltage,
  output logic [8:0]       secondaryVoltage,
  output logic [31:0]      primaryCurrent,
  output logic [2:0]       secondaryCurrent,
  output logic [2:0]       phaseInvert,
  output logic [1:0]       energyModeKvarh,
  output logic [1:0]       energyModeKwh,
  output out_action_e      outputAction,
  output pulse_src_e       pulseSource,
  output logic [11:0]      pulseRatio,
  output logic [8:0]       pulseLength,
  output logic [14:0]      remoteTimeout,
  output logic [1:0]       pulseDivider,
  output logic [9:0]       pulseUnitKwh
);

  // -------------------------------------------------
  // setting slot map
  // -------------------------------------------------
  // slot 0  nominal current display range
  // slot 1  wiring type, 0 four wire, 1 three wire
  // slot 2  voltage transformer in use
  // slot 3  primary voltage
  // slot 4  secondary voltage
  // slot 5  primary current, no upper limit
  // slot 6  secondary current, 1 or 5 only
  // slot 7  phase polarity bits
  // slot 8  energy modes, high half reactive
  // slot 9  output zero action
  // slot 10 pulse source index
  // slot 11 pulses per energy unit
  // slot 12 pulse length
  // slot 13 remote timeout in seconds
  // slot 14 energy unit divider index
  // every slot is one whole word at its base
  // offset; the even offset above it is unmapped

  // -------------------------------------------------
  // status word map
  // -------------------------------------------------
  // bit 31 bus password protection, live
  // bit 27 current overload, live
  // bit 26 voltage overload, live
  // bit 25 configuration menu, live
  // bit 17 pulse output overload, live
  // bit 12 counters changed, latched
  // bit 11 device rebooted, latched
  // bit 10 pulse output overload, latched
  // bit 8  parameters changed, latched
  // live bits lag their inputs by one cycle;
  // latched bits clear only by acknowledge or reset

  // -------------------------------------------------
  // acknowledge mask
  // -------------------------------------------------
  // data bit 0 parameters changed
  // data bit 1 pulse overload
  // data bit 2 rebooted
  // data bit 3 counters changed
  // a zero mask acknowledges every flag

  // -------------------------------------------------
  // decode helpers
  // -------------------------------------------------

  // setting slot of a word offset, none when unmapped
  function automatic logic [3:0] setIdx(input logic [15:0] a);
    case (a)
      `OFS_NOMI:    setIdx = 4'h0;
      `OFS_WIRING:  setIdx = 4'h1;
      `OFS_VTUSED:  setIdx = 4'h2;
      `OFS_PRIV:    setIdx = 4'h3;
      `OFS_SECV:    setIdx = 4'h4;
      `OFS_PRII:    setIdx = 4'h5;
      `OFS_SECI:    setIdx = 4'h6;
      `OFS_DIR:     setIdx = 4'h7;
      `OFS_ENERGY:  setIdx = 4'h8;
      `OFS_ACTION:  setIdx = 4'h9;
      `OFS_SOURCE:  setIdx = 4'hA;
      `OFS_RATIO:   setIdx = 4'hB;
      `OFS_LENGTH:  setIdx = 4'hC;
      `OFS_TMO:     setIdx = 4'hD;
      `OFS_DIVIDER: setIdx = 4'hE;
      default:      setIdx = `IDX_NONE;
    endcase
  endfunction

  // legal value window of each setting
  function automatic logic inRange(input logic [3:0] i, input logic [31:0] v);
    case (i)
      4'h0:    inRange = (v != `RST_ZERO) && (v <= `MAX_NOMI);
      4'h1:    inRange = (v <= `RST_ONE);
      4'h2:    inRange = (v <= `RST_ONE);
      4'h3:    inRange = (v != `RST_ZERO) && (v <= `MAX_PRIV);
      4'h4:    inRange = (v != `RST_ZERO) && (v <= `MAX_SECV);
      4'h5:    inRange = (v != `RST_ZERO);
      4'h6:    inRange = (v == `RST_ONE) || (v == `SECI_ALT);
      4'h7:    inRange = (v <= `MAX_DIR);
      4'h8:    inRange = (v[31:16] <= `MAX_MODE) && (v[15:0] <= `MAX_MODE);
      4'h9:    inRange = (v <= `MAX_ACTION);
      4'hA:    inRange = (v <= `MAX_SOURCE);
      4'hB:    inRange = (v != `RST_ZERO) && (v <= `MAX_RATIO);
      4'hC:    inRange = (v >= `MIN_LENGTH) && (v <= `MAX_LENGTH);
      4'hD:    inRange = (v <= `MAX_TMO);
      4'hE:    inRange = (v <= `MAX_DIVIDER);
      default: inRange = 1'b0;
    endcase
  endfunction

  // reset contents of each setting
  function automatic logic [31:0] setDefault(input int i);
    case (i)
      0, 3, 4, 5, 6, 11: setDefault = `RST_ONE;
      12:                setDefault = `MIN_LENGTH;
      default:           setDefault = `RST_ZERO;
    endcase
  endfunction

  // -------------------------------------------------
  // state
  // -------------------------------------------------
  regs_s q;
  regs_s d;
  logic  [31:0] statusWord;
  logic  [3:0]  wrIdx;
  logic  [3:0]  rdIdx;

  // device status and diagnostics word
  always_comb begin
    statusWord               = '0;
    statusWord[`BIT_MENU]    = q.live[1];
    statusWord[`BIT_VOLT]    = q.live[2];
    statusWord[`BIT_CURR]    = q.live[3];
    statusWord[`BIT_PASSWD]  = q.live[4];
    statusWord[`BIT_PULSE]   = q.live[0];
    statusWord[`BIT_PARAM]   = q.latched[0];
    statusWord[`BIT_PULSEL]  = q.latched[1];
    statusWord[`BIT_REBOOT]  = q.latched[2];
    statusWord[`BIT_COUNTER] = q.latched[3];
  end

  assign wrIdx = setIdx(reqAddr);
  assign rdIdx = wrIdx;

  // -------------------------------------------------
  // next state
  // -------------------------------------------------
  always_comb begin
    logic [3:0] setEv;
    logic [3:0] clrEv;
    d          = q;
    setEv      = '0;
    clrEv      = '0;
    d.rspValid = 1'b0;

    // input pin filter, counts once second and third stages agree
    d.diSync = {q.diSync[1:0], digitalInputZero};
    if (q.diSync[1] == q.diSync[2]) begin
      d.diLevel = q.diSync[2];
    end
    d.doLevel = digitalOutputZero;

    // live bits sampled each cycle, no acknowledge
    d.live = {busPasswordOn,
              currOverload,
              voltOverload,
              cfgMenuActive,
              pulseOverload};

    setEv[1] = pulseOverload & ~q.live[0];
    setEv[3] = countersChangedEvt;

    if (reqValid) begin
      d.rspValid   = 1'b1;
      d.rspExc     = 1'b0;
      d.rspExcCode = '0;
      d.rspData    = '0;
      case (reqFunc)
        `FC_RD_DISC: begin
          case (reqAddr)
            `DSC_PARAM:   d.rspData[0] = q.latched[0];
            `DSC_PULSEL:  d.rspData[0] = q.latched[1];
            `DSC_REBOOT:  d.rspData[0] = q.latched[2];
            `DSC_COUNTER: d.rspData[0] = q.latched[3];
            `DSC_PULSE:   d.rspData[0] = q.live[0];
            `DSC_MENU:    d.rspData[0] = q.live[1];
            `DSC_VOLT:    d.rspData[0] = q.live[2];
            `DSC_CURR:    d.rspData[0] = q.live[3];
            `DSC_INPUT:   d.rspData[0] = q.diLevel;
            `DSC_OUTPUT:  d.rspData[0] = q.doLevel;
            default: begin
              d.rspExc     = 1'b1;
              d.rspExcCode = `EXC_ADDR;
            end
          endcase
        end
        // status word by either read code
        `FC_RD_HOLD, `FC_RD_INP: begin
          if (reqAddr == `OFS_STATUS) begin
            d.rspData = statusWord;
          end else if (reqAddr == `OFS_OUTWORD) begin
            d.rspData = {31'h00000000, q.doLevel};
          end else if (reqAddr == `OFS_INWORD) begin
            d.rspData = {31'h00000000, q.diLevel};
          end else if (rdIdx != `IDX_NONE) begin
            d.rspData = q.setting[rdIdx];
          end else begin
            d.rspExc     = 1'b1;
            d.rspExcCode = `EXC_ADDR;
          end
        end
        `FC_WR_ONE: begin
          if (reqAddr == `OFS_ACK) begin
            clrEv = (reqData[3:0] == 4'h0) ? 4'hF : reqData[3:0];
          end else begin
            d.rspExc     = 1'b1;
            d.rspExcCode = (wrIdx != `IDX_NONE) ? `EXC_FUNC : `EXC_ADDR;
          end
        end
        // settings written by write multiple only
        `FC_WR_MANY: begin
          if (wrIdx == `IDX_NONE) begin
            d.rspExc     = 1'b1;
            d.rspExcCode = (reqAddr == `OFS_ACK) ? `EXC_FUNC : `EXC_ADDR;
          end else if (!inRange(wrIdx, reqData)) begin
            d.rspExc     = 1'b1;
            d.rspExcCode = `EXC_VALUE;
          end else begin
            d.setting[wrIdx] = reqData;
            setEv[0]         = 1'b1;
          end
        end
        default: begin
          d.rspExc     = 1'b1;
          d.rspExcCode = `EXC_FUNC;
        end
      endcase
    end

    // set wins over a clear in the same cycle
    d.latched = (q.latched & ~clrEv) | setEv;

    case (d.setting[14][1:0])
      2'h0:    d.unitKwh = 10'h001;
      2'h1:    d.unitKwh = 10'h00A;
      2'h2:    d.unitKwh = 10'h064;
      default: d.unitKwh = 10'h3E8;
    endcase
  end

  // -------------------------------------------------
  // registers
  // -------------------------------------------------

  // live bits clear, reboot flag set at restart
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q         <= '0;
      q.latched <= `RST_LATCHED;
      q.unitKwh <= 10'h001;
      for (int i = 0; i < `NSET; i++) begin
        q.setting[i] <= setDefault(i);
      end
    end else begin
      q <= d;
    end
  end

  // -------------------------------------------------
  // outputs
  // -------------------------------------------------

  // answer to the request of the previous cycle
  assign rspValid   = q.rspValid;
  assign rspExc     = q.rspExc;
  assign rspExcCode = q.rspExcCode;
  assign rspData    = q.rspData;

  // wiring and transformer settings; secondary voltage
  // and current narrowed to the widths that their ranges need
  assign nominalRange     = q.setting[0];
  assign wiringType       = q.setting[1][0];
  assign vtUsed           = q.setting[2][0];
  assign primaryVoltage   = q.setting[3];
  assign secondaryVoltage = q.setting[4][8:0];
  assign primaryCurrent   = q.setting[5];
  assign secondaryCurrent = q.setting[6][2:0];
  assign phaseInvert      = q.setting[7][2:0];
  // energy modes, one per half word
  assign energyModeKvarh  = q.setting[8][17:16];
  assign energyModeKwh    = q.setting[8][1:0];
  assign outputAction     = out_action_e'(q.setting[9][1:0]);
  assign pulseSource      = pulse_src_e'(q.setting[10][1:0]);
  assign pulseRatio       = q.setting[11][11:0];
  assign pulseLength      = q.setting[12][8:0];
  assign remoteTimeout    = q.setting[13][14:0];
  // divider index and its registered unit
  assign pulseDivider     = q.setting[14][1:0];
  assign pulseUnitKwh     = q.unitKwh;

endmodule

// ### modbus_master_model.sv
// master side model: issues one decoded request and takes its answer
// assumes the bank registers its answer on the taking edge
`timescale 1ns/1ps

module modbus_master_model (
  input  logic        core_clk,
  output logic        reqValid,
  output logic [7:0]  reqFunc,
  output logic [15:0] reqAddr,
  output logic [31:0] reqData,
  input  logic        rspValid,
  input  logic        rspExc,
  input  logic [7:0]  rspExcCode,
  input  logic [31:0] rspData
);
  // idle bus at time zero
  initial begin
    reqValid = 1'b0;
    reqFunc  = 8'h0;
    reqAddr  = 16'h0;
    reqData  = 32'h0;
  end

  // ---------------
  // one transfer
  // ---------------
  // settings by 0x10, ack by 0x06
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [31:0] d,
                      output logic [7:0] c, output logic [31:0] q, output logic ok);
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqFunc  <= f;
    reqAddr  <= a;
    reqData  <= d;
    @(posedge core_clk);
    reqValid <= 1'b0;
    reqFunc  <= ~f;  // released lines carry no stale value
    reqAddr  <= ~a;
    reqData  <= ~d;
    #1;
    ok = rspValid && (rspExc == (rspExcCode != 8'h0));
    c  = rspExcCode;
    q  = rspData;
  endtask
endmodule

// ### testbench.sv
// self-checking bench of the meter register bank
// assumes the bank, its checker and the master model compile first
`timescale 1ns/1ps

module testbench
  import meter_regs_pkg::*;
;
  typedef struct packed {
    logic [6:0]  p;
    logic [7:0]  f;
    logic [15:0] a;
    logic [31:0] d;
    logic [7:0]  c;
    logic [31:0] e;
  } row_s;

  logic        core_clk = 1'b0;
  logic        arst_n;
  logic        reqValid, rspValid, rspExc, cntEvt;
  logic [7:0]  reqFunc, rspExcCode;
  logic [15:0] reqAddr;
  logic [31:0] reqData, rspData;
  logic [6:0]  pins;
  logic [2:0]  phaseInvert;
  logic [8:0]  pulseLength;
  logic [9:0]  pulseUnitKwh;
  logic [31:0] nominalRange, primaryVoltage, primaryCurrent;
  logic        wiringType, vtUsed;
  logic [8:0]  secondaryVoltage;
  logic [2:0]  secondaryCurrent;
  logic [1:0]  energyModeKvarh, energyModeKwh, pulseDivider;
  logic [11:0] pulseRatio;
  logic [14:0] remoteTimeout;
  out_action_e outputAction;
  pulse_src_e  pulseSource;
  int          n_fail = 0;
  int          total_checks = 0;

  // pins: input, output, menu, volt, curr, password, pulse
  row_s rows [38] = '{
    '{7'h00,8'h03,16'h00CD,32'h0,8'h0,32'h800}, '{7'h00,8'h04,16'h00CD,32'h0,8'h0,32'h800},
    '{7'h00,8'h02,16'h006F,32'h0,8'h0,32'h1}, '{7'h00,8'h03,16'hC37B,32'h0,8'h0,32'h0},
    '{7'h00,8'h04,16'hC379,32'h0,8'h0,32'h1E}, '{7'h1E,8'h03,16'h00CD,32'h0,8'h0,32'h8E000800},
    '{7'h1E,8'h02,16'h007D,32'h0,8'h0,32'h1}, '{7'h1E,8'h02,16'h007F,32'h0,8'h0,32'h1},
    '{7'h60,8'h03,16'h00D1,32'h0,8'h0,32'h1}, '{7'h60,8'h04,16'h00CF,32'h0,8'h0,32'h1},
    '{7'h60,8'h02,16'h00C8,32'h0,8'h0,32'h1}, '{7'h60,8'h02,16'h012C,32'h0,8'h0,32'h1},
    '{7'h01,8'h03,16'h00CD,32'h0,8'h0,32'h20C00}, '{7'h01,8'h02,16'h0075,32'h0,8'h0,32'h1},
    '{7'h00,8'h02,16'h006E,32'h0,8'h0,32'h1}, '{7'h00,8'h02,16'h0075,32'h0,8'h0,32'h0},
    '{7'h00,8'h10,16'hC379,32'h1F4,8'h0,32'h0}, '{7'h00,8'h10,16'hC379,32'h1D,8'h3,32'h0},
    '{7'h00,8'h10,16'hC369,32'h20001,8'h0,32'h0},
    '{7'h00,8'h10,16'hC377,32'hFA1,8'h3,32'h0}, '{7'h00,8'h10,16'hC37B,32'h4651,8'h3,32'h0},
    '{7'h00,8'h03,16'hC379,32'h0,8'h0,32'h1F4}, '{7'h00,8'h10,16'hC363,32'h7,8'h0,32'h0},
    '{7'h00,8'h10,16'hC363,32'h8,8'h3,32'h0}, '{7'h00,8'h10,16'hC373,32'h2,8'h0,32'h0},
    '{7'h00,8'h10,16'hC373,32'h3,8'h3,32'h0}, '{7'h00,8'h10,16'hC375,32'h3,8'h0,32'h0},
    '{7'h00,8'h10,16'hC375,32'h4,8'h3,32'h0}, '{7'h00,8'h10,16'hC37D,32'h3,8'h0,32'h0},
    '{7'h00,8'h10,16'hC37D,32'h4,8'h3,32'h0}, '{7'h00,8'h06,16'hC379,32'h1,8'h1,32'h0},
    '{7'h00,8'h03,16'hC37A,32'h0,8'h2,32'h0}, '{7'h00,8'h02,16'h0071,32'h0,8'h2,32'h0},
    '{7'h00,8'h03,16'h00CD,32'h0,8'h0,32'hD00}, '{7'h00,8'h06,16'hEA67,32'h4,8'h0,32'h0},
    '{7'h00,8'h03,16'h00CD,32'h0,8'h0,32'h500}, '{7'h00,8'h06,16'hEA67,32'h0,8'h0,32'h0},
    '{7'h00,8'h03,16'h00CD,32'h0,8'h0,32'h0}};

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  meter_status_settings_regs u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .reqValid(reqValid), .reqFunc(reqFunc),
    .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspExc(rspExc),
    .rspExcCode(rspExcCode), .rspData(rspData), .digitalInputZero(pins[6]),
    .digitalOutputZero(pins[5]), .cfgMenuActive(pins[4]), .voltOverload(pins[3]),
    .currOverload(pins[2]), .busPasswordOn(pins[1]), .pulseOverload(pins[0]),
    .countersChangedEvt(cntEvt), .nominalRange(nominalRange), .wiringType(wiringType),
    .vtUsed(vtUsed), .primaryVoltage(primaryVoltage), .secondaryVoltage(secondaryVoltage),
    .primaryCurrent(primaryCurrent), .secondaryCurrent(secondaryCurrent),
    .phaseInvert(phaseInvert), .energyModeKvarh(energyModeKvarh),
    .energyModeKwh(energyModeKwh), .outputAction(outputAction),
    .pulseSource(pulseSource), .pulseRatio(pulseRatio), .pulseLength(pulseLength),
    .remoteTimeout(remoteTimeout), .pulseDivider(pulseDivider),
    .pulseUnitKwh(pulseUnitKwh));

  modbus_master_model u_mst (
    .core_clk(core_clk), .reqValid(reqValid), .reqFunc(reqFunc), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspExc(rspExc), .rspExcCode(rspExcCode),
    .rspData(rspData));

  // ---------------
  // helpers
  // ---------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask

  // set pins, let them settle, then one request
  task automatic req(input row_s r);
    logic [7:0]  c;
    logic [31:0] q;
    logic        ok;
    @(posedge core_clk);
    pins <= r.p;
    repeat (3) @(posedge core_clk);
    u_mst.xfer(r.f, r.a, r.d, c, q, ok);
    chk(32'(ok), 32'h1);
    chk(32'(c), 32'(r.c));
    chk(q, r.e);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------
  // main sequence
  // ---------------
  initial begin
    arst_n = 1'b0;
    pins   = 7'h0;
    cntEvt = 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    foreach (rows[i]) req(rows[i]);
    $display("table test done");
    chk(32'(phaseInvert), 32'h7);
    chk(32'(outputAction), 32'(ACT_PULSE));
    chk(32'(pulseSource), 32'(SRC_EXP_Q));
    chk(32'(pulseLength), 32'h1F4);
    chk(32'(pulseUnitKwh), 32'h3E8);
    chk(32'(pulseDivider), 32'h3);
    chk(32'(energyModeKvarh), 32'h2);
    chk(32'(energyModeKwh), 32'h1);
    chk(32'(pulseRatio), 32'h1);
    chk(32'(remoteTimeout), 32'h0);
    $display("setting outputs test done");
    // event in the ack cycle wins
    fork
      req('{7'h0, 8'h06, 16'hEA67, 32'h0, 8'h0, 32'h0});
      begin
        repeat (5) @(posedge core_clk);
        cntEvt <= 1'b1;
        @(posedge core_clk);
        cntEvt <= 1'b0;
      end
    join
    req('{7'h0, 8'h03, 16'h00CD, 32'h0, 8'h0, 32'h1000});
    req('{7'h0, 8'h06, 16'hEA67, 32'h8, 8'h0, 32'h0});
    req('{7'h0, 8'h03, 16'h00CD, 32'h0, 8'h0, 32'h0});
    $display("ack race test done");
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    req('{7'h0, 8'h03, 16'h00CD, 32'h0, 8'h0, 32'h800});
    req('{7'h0, 8'h03, 16'hC379, 32'h0, 8'h0, 32'h1E});
    chk(nominalRange, 32'h1);
    chk(32'(wiringType), 32'h0);
    chk(32'(vtUsed), 32'h0);
    chk(primaryVoltage, 32'h1);
    chk(32'(secondaryVoltage), 32'h1);
    chk(primaryCurrent, 32'h1);
    chk(32'(secondaryCurrent), 32'h1);
    chk(32'({energyModeKvarh, energyModeKwh}), 32'h0);
    chk(32'(pulseDivider), 32'h0);
    chk(32'(pulseUnitKwh), 32'h1);
    $display("second reset test done");
    end_of_test();
  end

  // watchdog: about 45 requests of 6 cycles, with wide margin
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule
